// file: rtl/scs_gain_if.sv
// Carrier between the sequencer and its gain trim block.
// Assumes both ends share clk.
interface scs_gain_if;
   logic wrStb;
   logic [15:0] wrData;
   logic [15:0] rdData;
   logic scaleStb;
   scs_pkg::scs_sample_t rawSample;
   scs_pkg::scs_sample_t scaledSample;
   modport seq (output wrStb, output wrData, output scaleStb, output rawSample,
      input rdData, input scaledSample);
   modport trim (input wrStb, input wrData, input scaleStb, input rawSample,
      output rdData, output scaledSample);
endinterface

// file: rtl/scs_gain_trim.sv
// Gain trim register and result scaling.
// Assumes a synchronised active-low reset and a clock enable from the sequencer.
`include "scs_regs.svh"
module scs_gain_trim (
   // Clock and reset
   input wire logic clk,
   input wire logic rstSync_n,
   input wire logic clkEn,
   // Sequencer side
   scs_gain_if.trim gif
);
   logic [`SCS_GAIN_BITS-1:0] gain_r;
   logic signed [14:0] delta;
   // Wide enough for full-scale code times the largest gain offset and weight.
   logic signed [47:0] corr;
   logic signed [15:0] sum;

   // ------------------------------------------------------------------
   // Trim word
   // ------------------------------------------------------------------
   always_ff @(posedge clk or negedge rstSync_n) begin
      if (!rstSync_n) begin
         gain_r <= `SCS_GAIN_RESET;
      end else if (clkEn && gif.wrStb) begin
         gain_r <= gif.wrData[`SCS_GAIN_BITS-1:0];
      end
   end

   assign gif.rdData = {2'h0, gain_r};

   // ------------------------------------------------------------------
   // Scaling
   // ------------------------------------------------------------------
   // Each bit is half the weight of the one above; midscale is unity gain,
   // so the full word spans a span correction up to 1.025 of reference.
   always_comb begin
      delta = $signed({1'b0, gain_r}) - `SCS_GAIN_MID;
      corr = (48'($signed({1'b0, gif.rawSample})) * 48'(delta)) * 48'(`SCS_GAIN_K);
      sum = 16'($signed({4'h0, gif.rawSample}) + 16'(corr >>> 29));
   end

   always_ff @(posedge clk or negedge rstSync_n) begin
      if (!rstSync_n) begin
         gif.scaledSample <= 12'h000;
      end else if (clkEn && gif.scaleStb) begin
         if (sum < 0) begin
            gif.scaledSample <= 12'h000;
         end else if (sum > 16'sh0fff) begin
            gif.scaledSample <= 12'hfff;
         end else begin
            gif.scaledSample <= sum[11:0];
         end
      end
   end
endmodule

// file: rtl/scs_pkg.sv
// Types of the conversion sequencer.
// Assumes nothing beyond a SystemVerilog compiler.
package scs_pkg;
   typedef enum logic [1:0] {
      SCS_IDLE = 2'b00,
      SCS_WAIT_EDGE = 2'b01,
      SCS_CONVERT = 2'b10,
      SCS_CALIB = 2'b11
   } scs_state_e;
   typedef logic [11:0] scs_sample_t;
endpackage

// file: rtl/scs_regs.svh
// Register offsets, field positions, reset values and timing counts of the
// conversion sequencer. Assumes inclusion by bare name from rtl/.
`ifndef SCS_REGS_SVH
`define SCS_REGS_SVH

// ------------------------------------------------------------------
// Register selects on the parallel bus
// ------------------------------------------------------------------
`define SCS_ADDR_CTRL 2'h0
`define SCS_ADDR_CAL 2'h1
`define SCS_ADDR_RESULT 2'h2

// ------------------------------------------------------------------
// Control and status fields
// ------------------------------------------------------------------
`define SCS_BIT_STCAL 0
`define SCS_BIT_CALSEL_LO 1
`define SCS_BIT_CALSEL_HI 2
`define SCS_BIT_BUSY 4
`define SCS_BIT_TRIG 12
`define SCS_CALSEL_GAIN 2'h3

// ------------------------------------------------------------------
// Gain trim layout and reset
// ------------------------------------------------------------------
`define SCS_GAIN_BITS 14
`define SCS_GAIN_RESET 14'h2000
`define SCS_GAIN_MID 15'sh2000
// Weight of the gain MSB, 2.5 % of reference, scaled by 2^16.
`define SCS_GAIN_K 17'sh0666

// ------------------------------------------------------------------
// Timing
// ------------------------------------------------------------------
`define SCS_CLK_PS 4000
`define SCS_SETUP_PS 10000
`define SCS_SETUP_CYC ((`SCS_SETUP_PS + `SCS_CLK_PS - 1) / `SCS_CLK_PS)
// Master-clock half periods in one conversion: 16.5 periods.
`define SCS_CONV_HALVES 6'h21
`define SCS_CAL_HALVES 1024
`endif

// file: rtl/scs_sequencer.sv
// Conversion sequencer top: trigger pin, software start, master-clock timing,
// busy and track/hold control, power-up calibration and register access.
// Assumes the bus strobes come from logic on clk; the pins are asynchronous.
//
// Notes on behaviour
// - Gain trim is 16 bits, top two read zero, low 14 hold gain.
// - Gain bits are binary weighted, MSB worth 2.5 % of reference.
// - Result is scaled by gain; larger gain offsets a smaller input span.
// - Gain trim covers an input span up to 1.025 times reference.
// - A conversion starts from a trigger pin pulse or a control trigger bit.
// - Hold begins at trigger pin rise or at the end of the control write.
// - Conversion starts on next master fall after 10 ns setup, lasts 16.5 periods.
// - A missed setup makes the conversion last 17.5 master periods.
// - Busy falls when conversion completes; then the result may be read.
// - Software trigger bit clears when busy falls.
// - First trigger after power-up runs a self-calibration.
// - Track/hold returns to tracking when busy falls.
// - Busy status bit is one during conversion or calibration.
// - Calibration select bits both one address the gain trim alone.
`include "scs_regs.svh"
module scs_sequencer #(
   parameter int CAL_HALVES = `SCS_CAL_HALVES
) (
   // Clock, reset and enable
   input wire logic clk,
   input wire logic rst_n,
   input wire logic clkEn,
   // Pins
   input wire logic conversionTrigger_n,
   input wire logic masterClockInput,
   // Parallel register bus
   input wire logic busWr,
   input wire logic busRd,
   input wire logic [1:0] busAddr,
   input wire logic [15:0] busWrData,
   output logic [15:0] busRdData,
   // Converter side
   input wire scs_pkg::scs_sample_t rawSample,
   output logic busy,
   output logic trackHold,
   output logic calActive,
   output scs_pkg::scs_sample_t result
);
   logic [1:0] rstPipe_r;
   logic rstSync_n;
   logic [2:0] trigSync_r;
   logic [2:0] mclkSync_r;
   logic trigLvl_r;
   logic mclkLvl_r;
   logic trigRise;
   logic mclkFall;
   logic mclkEdge;
   logic wrHeld_r;
   logic [1:0] wrAddr_r;
   logic [15:0] wrData_r;
   logic wrEnd;
   logic swTrig_r;
   logic [1:0] calSel_r;
   logic calDone_r;
   logic busy_r;
   logic busyFall;
   logic startReq;
   logic [3:0] setupCnt_r;
   logic [10:0] halfCnt_r;
   scs_pkg::scs_state_e state_r;
   scs_gain_if gif ();

   function automatic logic isSel(input logic [1:0] a, input logic [1:0] s);
      isSel = (a == s);
   endfunction

   // ------------------------------------------------------------------
   // Reset release and pin synchronisers
   // ------------------------------------------------------------------
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rstPipe_r <= 2'h0;
      end else begin
         rstPipe_r <= {rstPipe_r[0], 1'b1};
      end
   end
   assign rstSync_n = rstPipe_r[1];

   // A level is accepted only once stages two and three agree, so a glitch
   // shorter than a clock never reaches the sequencer.
   always_ff @(posedge clk or negedge rstSync_n) begin
      if (!rstSync_n) begin
         trigSync_r <= 3'h7;
         mclkSync_r <= 3'h0;
         trigLvl_r <= 1'b1;
         mclkLvl_r <= 1'b0;
      end else if (clkEn) begin
         trigSync_r <= {trigSync_r[1:0], conversionTrigger_n};
         mclkSync_r <= {mclkSync_r[1:0], masterClockInput};
         if (trigSync_r[1] == trigSync_r[2]) begin
            trigLvl_r <= trigSync_r[2];
         end
         if (mclkSync_r[1] == mclkSync_r[2]) begin
            mclkLvl_r <= mclkSync_r[2];
         end
      end
   end

   assign trigRise = !trigLvl_r && (trigSync_r[1] == trigSync_r[2]) && trigSync_r[2];
   assign mclkEdge = (mclkSync_r[1] == mclkSync_r[2]) && (mclkLvl_r != mclkSync_r[2]);
   assign mclkFall = mclkEdge && mclkLvl_r;

   // ------------------------------------------------------------------
   // Register writes
   // ------------------------------------------------------------------
   // Writes take effect when the strobe ends, which is the moment hold begins.
   always_ff @(posedge clk or negedge rstSync_n) begin
      if (!rstSync_n) begin
         wrHeld_r <= 1'b0;
         wrAddr_r <= 2'h0;
         wrData_r <= 16'h0000;
      end else if (clkEn) begin
         wrHeld_r <= busWr;
         if (busWr) begin
            wrAddr_r <= busAddr;
            wrData_r <= busWrData;
         end
      end
   end
   assign wrEnd = wrHeld_r && !busWr;

   always_ff @(posedge clk or negedge rstSync_n) begin
      if (!rstSync_n) begin
         calSel_r <= 2'h0;
      end else if (clkEn && wrEnd && isSel(wrAddr_r, `SCS_ADDR_CTRL)) begin
         calSel_r <= {wrData_r[`SCS_BIT_CALSEL_HI], wrData_r[`SCS_BIT_CALSEL_LO]};
      end
   end

   // A new set in the same cycle as the busy fall wins over the clear.
   always_ff @(posedge clk or negedge rstSync_n) begin
      if (!rstSync_n) begin
         swTrig_r <= 1'b0;
      end else if (clkEn) begin
         if (wrEnd && isSel(wrAddr_r, `SCS_ADDR_CTRL) && wrData_r[`SCS_BIT_TRIG]) begin
            swTrig_r <= 1'b1;
         end else if (busyFall) begin
            swTrig_r <= 1'b0;
         end
      end
   end

   assign gif.wrStb = clkEn && wrEnd && isSel(wrAddr_r, `SCS_ADDR_CAL)
      && (calSel_r == `SCS_CALSEL_GAIN);
   assign gif.wrData = wrData_r;

   // ------------------------------------------------------------------
   // Sequencing
   // ------------------------------------------------------------------
   assign startReq = trigRise || (wrEnd && isSel(wrAddr_r, `SCS_ADDR_CTRL)
      && wrData_r[`SCS_BIT_TRIG]);

   always_ff @(posedge clk or negedge rstSync_n) begin
      if (!rstSync_n) begin
         state_r <= scs_pkg::SCS_IDLE;
         setupCnt_r <= 4'h0;
         halfCnt_r <= 11'h000;
         calDone_r <= 1'b0;
      end else if (clkEn) begin
         case (state_r)
            scs_pkg::SCS_IDLE: begin
               setupCnt_r <= 4'h0;
               halfCnt_r <= 11'h000;
               if (startReq) begin
                  state_r <= calDone_r ? scs_pkg::SCS_WAIT_EDGE
                     : scs_pkg::SCS_CALIB;
               end
            end
            scs_pkg::SCS_WAIT_EDGE: begin
               if (setupCnt_r < 4'(`SCS_SETUP_CYC)) begin
                  setupCnt_r <= setupCnt_r + 4'h1;
               end
               // An edge inside the setup window is skipped: one period more.
               if (mclkFall && setupCnt_r >= 4'(`SCS_SETUP_CYC)) begin
                  state_r <= scs_pkg::SCS_CONVERT;
               end
            end
            scs_pkg::SCS_CONVERT: begin
               if (mclkEdge) begin
                  halfCnt_r <= halfCnt_r + 11'h001;
                  if (halfCnt_r == 11'({5'h00, `SCS_CONV_HALVES}) - 11'h001) begin
                     state_r <= scs_pkg::SCS_IDLE;
                  end
               end
            end
            scs_pkg::SCS_CALIB: begin
               if (mclkEdge) begin
                  halfCnt_r <= halfCnt_r + 11'h001;
                  if (halfCnt_r == 11'(CAL_HALVES - 1)) begin
                     state_r <= scs_pkg::SCS_IDLE;
                     calDone_r <= 1'b1;
                  end
               end
            end
            default: begin
               state_r <= scs_pkg::SCS_IDLE;
            end
         endcase
      end
   end
   // Triggers in any state but idle fall through the case unseen.

   always_ff @(posedge clk or negedge rstSync_n) begin
      if (!rstSync_n) begin
         busy_r <= 1'b0;
      end else if (clkEn) begin
         busy_r <= (state_r != scs_pkg::SCS_IDLE);
      end
   end
   assign busyFall = busy_r && (state_r == scs_pkg::SCS_IDLE);
   assign busy = busy_r;
   assign calActive = (state_r == scs_pkg::SCS_CALIB);
   // Hold from the start request until the busy fall returns to track.
   assign trackHold = busy_r;

   // ------------------------------------------------------------------
   // Result capture and reads
   // ------------------------------------------------------------------
   assign gif.rawSample = rawSample;
   assign gif.scaleStb = clkEn && (state_r == scs_pkg::SCS_CONVERT) && mclkEdge
      && (halfCnt_r == 11'({5'h00, `SCS_CONV_HALVES}) - 11'h001);
   assign result = gif.scaledSample;

   always_ff @(posedge clk or negedge rstSync_n) begin
      if (!rstSync_n) begin
         busRdData <= 16'h0000;
      end else if (clkEn && busRd) begin
         case (busAddr)
            `SCS_ADDR_CTRL: begin
               busRdData <= 16'h0000 | (16'(busy_r) << `SCS_BIT_BUSY)
                  | (16'(calSel_r) << `SCS_BIT_CALSEL_LO)
                  | (16'(swTrig_r) << `SCS_BIT_TRIG)
                  | (16'(calActive) << `SCS_BIT_STCAL);
            end
            `SCS_ADDR_CAL: begin
               busRdData <= (calSel_r == `SCS_CALSEL_GAIN) ? gif.rdData : 16'h0000;
            end
            `SCS_ADDR_RESULT: begin
               busRdData <= {4'h0, gif.scaledSample};
            end
            default: begin
               busRdData <= 16'h0000;
            end
         endcase
      end
   end

   scs_gain_trim u_trim (
      .clk(clk),
      .rstSync_n(rstSync_n),
      .clkEn(clkEn),
      .gif(gif.trim)
   );
endmodule

// file: verif/scs_host_model.sv
// Host on the parallel bus: register tasks, trigger pin, master clock.
// Assumes everything is driven just after the rising edge of clk.
module scs_host_model #(
   parameter int MHALF = 31
) (
   // Clock
   input wire logic clk,
   // Bus
   output logic busWr,
   output logic busRd,
   output logic [1:0] busAddr,
   output logic [15:0] busWrData,
   input wire logic [15:0] busRdData,
   // Pins
   output logic conversionTrigger_n,
   output logic masterClockInput
);
   timeunit 1ns;
   timeprecision 1ps;
   int mCnt;
   initial begin
      busWr = 1'b0;
      busRd = 1'b0;
      busAddr = 2'h0;
      busWrData = 16'h0000;
      conversionTrigger_n = 1'b1;
      masterClockInput = 1'b0;
      mCnt = 0;
   end
   // Free running master clock near 4 MHz.
   always @(posedge clk) begin
      mCnt <= (mCnt == MHALF - 1) ? 0 : mCnt + 1;
      if (mCnt == MHALF - 1) masterClockInput <= ~masterClockInput;
   end
   // Idle lines show the inverse of their last value, never a stale copy.
   task automatic wr(input logic [1:0] a, input logic [15:0] d);
      @(posedge clk);
      busWr <= 1'b1;
      busAddr <= a;
      busWrData <= d;
      @(posedge clk);
      busWr <= 1'b0;
      @(posedge clk);
      busAddr <= ~a;
      busWrData <= ~d;
   endtask
   // Write whose strobe stays up for n cycles; it takes effect at its end.
   task automatic wrLong(input logic [1:0] a, input logic [15:0] d, input int n);
      @(posedge clk);
      busWr <= 1'b1;
      busAddr <= a;
      busWrData <= d;
      repeat (n) @(posedge clk);
      busWr <= 1'b0;
      @(posedge clk);
      busAddr <= ~a;
      busWrData <= ~d;
   endtask
   task automatic rd(input logic [1:0] a, output logic [15:0] d);
      @(posedge clk);
      busRd <= 1'b1;
      busAddr <= a;
      @(posedge clk);
      busRd <= 1'b0;
      @(posedge clk);
      busAddr <= ~a;
      @(negedge clk);
      d = busRdData;
   endtask
   task automatic pulse;
      @(posedge clk);
      conversionTrigger_n <= 1'b0;
      repeat (4) @(posedge clk);
      conversionTrigger_n <= 1'b1;
   endtask
endmodule

// file: verif/scs_seq_assertions.sv
// Concurrent checks on the ports of the conversion sequencer top.
// Assumes binding to scs_sequencer with clkEn dropped by the bench only while idle.
module scs_seq_assertions (
   // Clock, reset and pins
   input wire logic clk, rst_n, clkEn, conversionTrigger_n, masterClockInput,
   // Register bus
   input wire logic busWr, busRd,
   input wire logic [1:0] busAddr,
   input wire logic [15:0] busWrData, busRdData,
   // Converter side
   input wire scs_pkg::scs_sample_t rawSample, result,
   input wire logic busy, trackHold, calActive
);
   timeunit 1ns;
   timeprecision 1ps;
   logic mPrev_r, busyPrev_r, firstDone_r;
   logic [5:0] fallCnt_r;
   // Master falls are counted raw; the design sees them a few clocks late,
   // so the accepted window is one fall wider on each side.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         mPrev_r <= 1'b0;
         fallCnt_r <= 6'h0;
      end else begin
         mPrev_r <= masterClockInput;
         if (!busy) fallCnt_r <= 6'h0;
         else if (mPrev_r && !masterClockInput) fallCnt_r <= fallCnt_r + 6'h1;
      end
   end
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         busyPrev_r <= 1'b0;
         firstDone_r <= 1'b0;
      end else begin
         busyPrev_r <= busy;
         firstDone_r <= firstDone_r | (busyPrev_r & ~busy);
      end
   end
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   property p_hold; trackHold == busy; endproperty
   a_hold: assert property (p_hold)
      else $error("hold state differs from busy");
   property p_gainTop; busRd && busAddr == 2'h1 |=> busRdData[15:14] == 2'h0; endproperty
   a_gainTop: assert property (p_gainTop)
      else $error("gain read has upper bits set");
   property p_status; (busRd && busAddr == 2'h0 && !busy) ##1 !busy |=> !busRdData[4]; endproperty
   a_status: assert property (p_status)
      else $error("status busy bit set while idle");
   property p_calBusy; calActive && $past(calActive) |-> busy; endproperty
   a_calBusy: assert property (p_calBusy)
      else $error("calibration without busy");
   property p_convLen; $fell(busy) && firstDone_r |-> fallCnt_r >= 6'h10 && fallCnt_r <= 6'h12;
   endproperty
   a_convLen: assert property (p_convLen)
      else $error("conversion length out of range");
   property p_resEnd; $changed(result) |-> ##[0:2] !busy; endproperty
   a_resEnd: assert property (p_resEnd)
      else $error("result changed away from completion");
   property p_noRe; $fell(busy) |-> !busy [*2]; endproperty
   a_noRe: assert property (p_noRe)
      else $error("busy returned at once");
   property p_firstCal; $rose(busy) && !firstDone_r |-> ##[0:2] calActive; endproperty
   a_firstCal: assert property (p_firstCal)
      else $error("first request did not calibrate");
   property p_calOnce; firstDone_r |-> !calActive; endproperty
   a_calOnce: assert property (p_calOnce)
      else $error("calibration repeated");
endmodule

// file: verif/tb.sv
// Self-checking bench for the conversion sequencer.
// Assumes the host model drives the bus and pins; clkEn is high except for one frozen write in t_cal_reg.
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic clkEn = 1'b1;
   logic busWr, busRd, conversionTrigger_n, masterClockInput;
   logic [1:0] busAddr;
   logic [15:0] busWrData, busRdData;
   scs_pkg::scs_sample_t rawSample = 12'h000;
   scs_pkg::scs_sample_t result;
   logic busy, trackHold, calActive;
   int errTotal = 0;
   int checksDone = 0;
   int busyFalls = 0;
   always #2 clk = ~clk;
   always @(negedge busy) busyFalls <= busyFalls + 1;
   scs_host_model host (.clk(clk), .busWr(busWr), .busRd(busRd), .busAddr(busAddr),
      .busWrData(busWrData), .busRdData(busRdData),
      .conversionTrigger_n(conversionTrigger_n), .masterClockInput(masterClockInput));
   scs_sequencer #(.CAL_HALVES(8)) uut (.clk(clk), .rst_n(rst_n), .clkEn(clkEn),
      .conversionTrigger_n(conversionTrigger_n), .masterClockInput(masterClockInput),
      .busWr(busWr), .busRd(busRd), .busAddr(busAddr), .busWrData(busWrData),
      .busRdData(busRdData), .rawSample(rawSample), .busy(busy), .trackHold(trackHold),
      .calActive(calActive), .result(result));
   task automatic summarize;
      $display("checks %0d mismatches %0d", checksDone, errTotal);
      if (errTotal == 0 && checksDone > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      checksDone++;
      if (seen !== exp) begin
         errTotal++;
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
   endtask
   // Gain 0x2000 is unity; the MSB of the offset from it weighs 2.5 %.
   function automatic logic [15:0] scaled(input longint raw, input longint gain);
      longint v;
      v = raw + ((raw * (gain - 8192) * 1638) >>> 29);
      if (v > 4095) v = 4095;
      return 16'(v);
   endfunction
   task automatic waitBusy(input logic lvl);
      int n;
      n = 0;
      while (busy !== lvl && n < 3000) begin
         @(negedge clk);
         n++;
      end
      if (busy !== lvl) begin
         errTotal++;
         $display("[ERR] busy expected %b seen %b", lvl, busy);
         summarize();
      end
   endtask
   task automatic convert(input logic [11:0] raw, input logic [15:0] exp, input int ph);
      @(posedge clk);
      rawSample <= raw;
      repeat (ph) @(posedge clk);
      host.pulse();
      waitBusy(1'b1);
      waitBusy(1'b0);
      repeat (100) @(posedge clk);
      check("result", {4'h0, result}, exp);
   endtask
   task automatic t_cal_reg;
      logic [15:0] d;
      host.wr(2'h0, 16'h0006);
      host.rd(2'h1, d);
      check("gain reset", d, 16'h2000);
      host.wr(2'h1, 16'hffff);
      host.rd(2'h1, d);
      check("gain top bits", d, 16'h3fff);
      host.wr(2'h0, 16'h0002);
      host.rd(2'h1, d);
      check("gain unselected", d, 16'h0000);
      host.wr(2'h1, 16'h0123);
      host.wr(2'h0, 16'h0006);
      host.rd(2'h1, d);
      check("gain kept", d, 16'h3fff);
      // A write while the enable is low must leave no trace.
      @(posedge clk);
      clkEn <= 1'b0;
      host.wr(2'h1, 16'h0123);
      @(posedge clk);
      clkEn <= 1'b1;
      host.rd(2'h1, d);
      check("gain frozen", d, 16'h3fff);
   endtask
   task automatic t_power_up_cal;
      host.pulse();
      waitBusy(1'b1);
      check("cal active", {15'h0, calActive}, 16'h0001);
      waitBusy(1'b0);
      repeat (100) @(posedge clk);
   endtask
   task automatic t_pin_conv;
      for (int ph = 0; ph < 4; ph++) convert(12'h800, scaled(2048, 16383), ph * 11);
      host.wr(2'h1, 16'h2000);
      convert(12'h5a5, 16'h05a5, 0);
   endtask
   task automatic t_sw_conv;
      logic [15:0] d;
      int f0;
      @(posedge clk);
      rawSample <= 12'hfff;
      host.wr(2'h0, 16'h1006);
      waitBusy(1'b1);
      check("hold", {15'h0, trackHold}, 16'h0001);
      f0 = busyFalls;
      // The held write outlasts the busy fall and still leaves at least 1260 ns to acquire.
      host.wrLong(2'h0, 16'h1006, 1400);
      waitBusy(1'b1);
      waitBusy(1'b0);
      check("busy falls across held write", 16'(busyFalls - f0), 16'h0002);
      repeat (100) @(posedge clk);
      host.rd(2'h0, d);
      check("start and busy bits", d & 16'h1010, 16'h0000);
      check("sw result", {4'h0, result}, 16'h0fff);
   endtask
   task automatic t_retrigger;
      int n;
      n = 0;
      host.pulse();
      waitBusy(1'b1);
      repeat (200) @(posedge clk);
      host.pulse();
      waitBusy(1'b0);
      repeat (300) begin
         @(negedge clk);
         if (busy !== 1'b0) n++;
      end
      check("busy after ignored trigger", 16'(n), 16'h0000);
   endtask
   initial begin
      repeat (8) @(posedge clk);
      rst_n <= 1'b1;
      repeat (6) @(posedge clk);
      t_cal_reg();
      t_power_up_cal();
      t_pin_conv();
      t_sw_conv();
      t_retrigger();
      summarize();
   end
endmodule
bind scs_sequencer scs_seq_assertions chk (.clk(clk), .rst_n(rst_n), .clkEn(clkEn),
   .conversionTrigger_n(conversionTrigger_n), .masterClockInput(masterClockInput),
   .busWr(busWr), .busRd(busRd), .busAddr(busAddr), .busWrData(busWrData),
   .busRdData(busRdData), .rawSample(rawSample), .result(result), .busy(busy),
   .trackHold(trackHold), .calActive(calActive));
